// ==== rtl/cfg_pin_regs.svh ====
`ifndef CFG_PIN_REGS_SVH
`define CFG_PIN_REGS_SVH
// length of the internal memory clear, in clock cycles
`define CLEAR_CYCLES 16'h0040
// reset value of the byte-ready status
`define BYTE_READY_RST 1'b1
// busy time after each accepted byte, in clock cycles
`define BYTE_BUSY_CYCLES 8'h04
// master parallel read strobe half period, in clock cycles
`define READ_STROBE_HALF 8'h02
// position of the status bit on the data bus
`define STATUS_BIT_POS 7
`endif

// ==== rtl/cfg_pin_pkg.sv ====
package cfg_pin_pkg;
  // configuration load modes
  typedef enum logic [1:0] {
    MODE_ASYNC_PERIPH,
    MODE_MASTER_PAR,
    MODE_OTHER
  } cfg_mode_t;
  // host strobes of the peripheral port
  typedef struct packed {
    logic select_active_low_n;
    logic select_active_high;
    logic rd_n;
    logic wr_n;
  } host_strobe_t;
  // one open-drain or two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;
endpackage

// ==== rtl/pin_sync3.sv ====
`timescale 1ns/1ns
// three-stage synchroniser: a change counts when stages two and three agree
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q; // metastable stage, only s2 reads it
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  // ---------------------------------------------------------------
  // shift chain
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // ---------------------------------------------------------------
  // agreement filter per bit
  // ---------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
        sync_out[i] <= INIT[i];
      end else if (s2_q[i] == s3_q[i]) begin
        sync_out[i] <= s3_q[i];
      end
    end
  end
endmodule

// ==== rtl/cfg_status_pins.sv ====
`timescale 1ns/1ns
`include "cfg_pin_regs.svh"

module cfg_status_pins (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire cfg_pin_pkg::cfg_mode_t mode_in, // strapped load mode
  input wire logic power_stable_in, // from on-chip power monitor
  input wire logic load_done_in, // last bitstream byte loaded
  input wire logic bscan_used_in, // boundary scan kept after config
  input wire logic clear_wait_n_in, // pin level, open-drain line
  input wire cfg_pin_pkg::host_strobe_t host_in, // async host pins
  input wire cfg_pin_pkg::pin_drive_t [2:0] user_pin_in, // user drive
  input wire cfg_pin_pkg::pin_drive_t [2:0] user_jtag_in,
  output cfg_pin_pkg::pin_drive_t clear_wait_n_out,
  output cfg_pin_pkg::pin_drive_t byte_ready_out, // ready/strobe pin
  output cfg_pin_pkg::pin_drive_t cfg_pending_high_flag_out,
  output cfg_pin_pkg::pin_drive_t cfg_pending_low_flag_out,
  output cfg_pin_pkg::pin_drive_t status_data_bit_out,
  output cfg_pin_pkg::pin_drive_t [2:0] jtag_pin_out, // tdi, tck, tms
  output logic byte_taken_out, // one-cycle pulse per selected host write in load
  output logic cfg_done_out // level, from register
);
  import cfg_pin_pkg::*;

  // ---------------------------------------------------------------
  // sequence states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_WAIT,
    ST_LOAD,
    ST_DONE
  } cfg_state_t;

  cfg_state_t state_q; // configuration sequence
  logic [15:0] clear_cnt_q; // memory clear timer
  logic [7:0] busy_cnt_q; // byte busy timer
  logic [7:0] strobe_cnt_q; // read strobe divider
  logic strobe_q; // read strobe level
  logic done_q; // single completion indication
  logic ready_q; // byte-ready status
  logic [4:0] pins_s; // synchronised: clear, cs_n, cs, rd_n, wr_n
  logic wr_n_prev_q; // for write edge
  logic clear_wait_s;
  logic selected;
  logic wr_fall;
  logic status_read;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // strobes idle high so no false write edge appears after reset
  pin_sync3 #(
    .WIDTH(5),
    .INIT(5'h1B)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .async_in({clear_wait_n_in, host_in.select_active_low_n,
               host_in.select_active_high, host_in.rd_n, host_in.wr_n}),
    .sync_out(pins_s)
  );

  assign clear_wait_s = pins_s[4];
  // selection needs both chip selects at once
  assign selected = !pins_s[3] && pins_s[2];
  assign wr_fall = wr_n_prev_q && !pins_s[0];
  // write strobe overrides a simultaneous read
  assign status_read = selected && !pins_s[1] && pins_s[0];

  // ---------------------------------------------------------------
  // configuration sequence
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_q <= ST_CLEAR;
      clear_cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_CLEAR: begin
          // memory clear starts only once power has settled
          if (power_stable_in) begin
            clear_cnt_q <= clear_cnt_q + 16'h0001;
          end
          if (clear_cnt_q == `CLEAR_CYCLES - 16'h0001) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // an outside party may stretch the wait by holding it low
          if (clear_wait_s) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (load_done_in) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // completion indication
  // ---------------------------------------------------------------
  // one register steers every pin so none changes role early
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_DONE);
    end
  end
  assign cfg_done_out = done_q;

  // ---------------------------------------------------------------
  // byte-ready handshake for asynchronous peripheral mode
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ready_q <= `BYTE_READY_RST;
      busy_cnt_q <= 8'h00;
      wr_n_prev_q <= 1'b1;
      byte_taken_out <= 1'b0;
    end else begin
      wr_n_prev_q <= pins_s[0];
      byte_taken_out <= 1'b0;
      if (state_q == ST_LOAD && selected && wr_fall) begin
        // byte taken: busy for a fixed time, then ready again
        ready_q <= 1'b0;
        busy_cnt_q <= `BYTE_BUSY_CYCLES;
        byte_taken_out <= 1'b1;
      end else if (busy_cnt_q != 8'h00) begin
        busy_cnt_q <= busy_cnt_q - 8'h01;
        ready_q <= (busy_cnt_q == 8'h01);
      end
    end
  end

  // ---------------------------------------------------------------
  // read strobe for master parallel mode
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in || state_q != ST_LOAD) begin
      strobe_cnt_q <= 8'h00;
      strobe_q <= 1'b1;
    end else if (strobe_cnt_q == `READ_STROBE_HALF - 8'h01) begin
      strobe_cnt_q <= 8'h00;
      strobe_q <= !strobe_q;
    end else begin
      strobe_cnt_q <= strobe_cnt_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      clear_wait_n_out <= '{o: 1'b0, oe: 1'b1};
      byte_ready_out <= '{o: 1'b0, oe: 1'b0};
      cfg_pending_high_flag_out <= '{o: 1'b1, oe: 1'b1};
      cfg_pending_low_flag_out <= '{o: 1'b0, oe: 1'b1};
      status_data_bit_out <= '{o: 1'b0, oe: 1'b0};
      jtag_pin_out <= '{default: '{o: 1'b0, oe: 1'b0}};
    end else if (done_q) begin
      // ready and both flag pins handed over to user logic together
      clear_wait_n_out <= '{o: 1'b0, oe: 1'b0};
      byte_ready_out <= user_pin_in[0];
      cfg_pending_high_flag_out <= user_pin_in[1];
      cfg_pending_low_flag_out <= user_pin_in[2];
      status_data_bit_out <= '{o: 1'b0, oe: 1'b0};
      // boundary scan keeps its pins if still in use
      if (bscan_used_in) begin
        jtag_pin_out <= '{default: '{o: 1'b0, oe: 1'b0}};
      end else begin
        jtag_pin_out <= user_jtag_in;
      end
    end else begin
      cfg_pending_high_flag_out <= '{o: 1'b1, oe: 1'b1};
      cfg_pending_low_flag_out <= '{o: 1'b0, oe: 1'b1};
      // open drain: only ever pulls low, released in wait and load
      clear_wait_n_out <= '{o: 1'b0, oe: (state_q == ST_CLEAR)};
      if (mode_in == MODE_ASYNC_PERIPH) begin
        byte_ready_out <= '{o: ready_q, oe: 1'b1};
      end else if (mode_in == MODE_MASTER_PAR) begin
        byte_ready_out <= '{o: strobe_q, oe: 1'b1};
      end else begin
        byte_ready_out <= '{o: 1'b0, oe: 1'b0};
      end
      status_data_bit_out <= '{o: ready_q,
        oe: status_read && mode_in == MODE_ASYNC_PERIPH};
      jtag_pin_out <= '{default: '{o: 1'b0, oe: 1'b0}};
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  a_high_flag_hold: assert property (
    !done_q |-> ##1
      cfg_pending_high_flag_out == pin_drive_t'{o: 1'b1, oe: 1'b1})
    else $error("high flag not held high before completion");
  a_low_flag_hold: assert property (
    !done_q |-> ##1
      cfg_pending_low_flag_out == pin_drive_t'{o: 1'b0, oe: 1'b1})
    else $error("low flag not held low before completion");
  a_clear_pull_low: assert property (
    state_q == ST_CLEAR && !done_q |-> ##1
      clear_wait_n_out.oe && !clear_wait_n_out.o)
    else $error("clear line not pulled low during clear");
  a_wait_holds: assert property (
    state_q == ST_WAIT && !clear_wait_s |=> state_q == ST_WAIT)
    else $error("left wait state while line held low");
  a_ready_returns: assert property (
    byte_taken_out |-> !ready_q ##4 ready_q)
    else $error("byte ready timing wrong");
  a_status_on_bit: assert property (
    !done_q && status_read && mode_in == MODE_ASYNC_PERIPH |=>
      status_data_bit_out.oe && status_data_bit_out.o == $past(ready_q))
    else $error("status missing on data bit");
  a_no_select_write: assert property (
    byte_taken_out |-> $past(selected))
    else $error("byte taken without selection");
  a_strobe_toggle: assert property (
    state_q == ST_LOAD && $past(state_q) == ST_LOAD && strobe_cnt_q == 8'h00
      |-> $changed(strobe_q))
    else $error("read strobe did not toggle");
  a_pins_released: assert property (
    done_q |=> byte_ready_out == $past(user_pin_in[0]) &&
      cfg_pending_high_flag_out == $past(user_pin_in[1]))
    else $error("status pins not released");
  a_jtag_kept: assert property (
    done_q |=>
      jtag_pin_out == ($past(bscan_used_in) ? '0 : $past(user_jtag_in)))
    else $error("jtag pin taken while scan in use");
  a_done_sticky: assert property (
    done_q |=> done_q && !clear_wait_n_out.oe &&
      cfg_pending_low_flag_out == $past(user_pin_in[2]))
    else $error("completion dropped");

  c_reach_done: cover property (!done_q ##1 done_q);
  c_byte_write: cover property (byte_taken_out);
  c_status_read: cover property (status_data_bit_out.oe);
  c_wait_stretch: cover property (state_q == ST_WAIT [*3]);
endmodule

// ==== tb/cfg_host_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// host side of the peripheral port
// ----------------------------------------
module cfg_host_model (
  input wire logic wr_req_in, // host wants a byte written
  input wire logic rd_req_in, // host wants the status read
  input wire logic sel_ok_in, // low leaves the device unselected
  input wire logic hold_low_in, // outside party delays loading
  input wire cfg_pin_pkg::pin_drive_t clear_pin_in,
  output cfg_pin_pkg::host_strobe_t host_out,
  output logic clear_wire_out
);
  import cfg_pin_pkg::*;
  // select needs low-n low and high high together
  // strobes are active low on the pins
  assign host_out = '{select_active_low_n: 1'b0,
    select_active_high: sel_ok_in, rd_n: !rd_req_in,
    wr_n: !wr_req_in};
  // pull-up wins unless some party pulls the line low
  assign clear_wire_out = !(clear_pin_in.oe || hold_low_in);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
  import cfg_pin_pkg::*;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic core_clk_in, srst_in, pwr, done_in, bscan, wr, rd, sel, hold;
  cfg_mode_t mode;
  host_strobe_t host;
  logic clear_wire;
  pin_drive_t [2:0] upin, ujtag;
  pin_drive_t clr, rdy, hi_f, lo_f, dbit;
  pin_drive_t [2:0] jtag;
  logic taken, cfg_done;
  int fail_count, n_tests, n;
  cfg_host_model host_m (.wr_req_in(wr), .rd_req_in(rd), .sel_ok_in(sel),
    .hold_low_in(hold), .clear_pin_in(clr), .host_out(host),
    .clear_wire_out(clear_wire));
  cfg_status_pins DUT (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .mode_in(mode), .power_stable_in(pwr), .load_done_in(done_in),
    .bscan_used_in(bscan), .clear_wait_n_in(clear_wire), .host_in(host),
    .user_pin_in(upin), .user_jtag_in(ujtag), .clear_wait_n_out(clr),
    .byte_ready_out(rdy), .cfg_pending_high_flag_out(hi_f),
    .cfg_pending_low_flag_out(lo_f), .status_data_bit_out(dbit),
    .jtag_pin_out(jtag), .byte_taken_out(taken), .cfg_done_out(cfg_done));
  // user drive o=1 oe=0 differs from every configuration value
  assign upin = {3{2'b10}};
  assign ujtag = {3{2'b11}};
  // ----------------------------------------
  // clock and scenarios
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_in);
  endtask
  task automatic do_reset(input cfg_mode_t m, input logic b);
    srst_in = 1'b1;
    mode = m;
    bscan = b;
    cyc(3);
    srst_in = 1'b0;
  endtask
  // clear stays while power unsettled, then lasts its count
  task automatic t_clear;
    cyc(80);
    `CHK(clr, 2'b01)
    `CHK(hi_f, 2'b11)
    `CHK(lo_f, 2'b01)
    pwr = 1'b1;
    n = 0;
    while (clr.oe === 1'b1 && n < 200) begin
      n++;
      cyc(1);
    end
    `CHK(n >= 62 && n <= 68, 1'b1)
  endtask
  // a held clear line keeps writes from being taken
  task automatic t_wait;
    wr = 1'b1;
    n = 0;
    repeat (12) begin
      cyc(1);
      n += taken;
    end
    `CHK(n, 0)
    wr = 1'b0;
    hold = 1'b0;
    cyc(8);
  endtask
  // unselected write refused, selected write runs busy for 4
  task automatic t_write;
    sel = 1'b0;
    wr = 1'b1;
    n = 0;
    repeat (10) begin
      cyc(1);
      n += taken;
    end
    `CHK(n, 0)
    wr = 1'b0;
    cyc(6);
    `CHK(rdy, 2'b11)
    sel = 1'b1;
    wr = 1'b1;
    for (int i = 0; i < 10 && taken !== 1'b1; i++) cyc(1);
    `CHK(taken, 1'b1)
    wr = 1'b0;
    cyc(1);
    `CHK(rdy, 2'b01)
    cyc(3);
    `CHK(rdy.o, 1'b0)
    cyc(1);
    `CHK(rdy, 2'b11)
  endtask
  // status read puts the ready level on the data bit
  task automatic t_read;
    rd = 1'b1;
    cyc(6);
    `CHK(dbit, 2'b11)
    rd = 1'b0;
    cyc(6);
    `CHK(dbit.oe, 1'b0)
  endtask
  // read strobe toggles every two cycles in master parallel
  task automatic t_strobe;
    logic [3:0] s;
    for (int i = 0; i < 4; i++) begin
      s[i] = rdy.o;
      cyc(1);
    end
    `CHK(rdy.oe, 1'b1)
    `CHK(s[0] ^ s[2], 1'b1)
    `CHK(s[1] ^ s[3], 1'b1)
    `CHK(s[0] ^ s[1] ^ s[2] ^ s[3], 1'b0)
  endtask
  // completion hands ready and both flag pins over in the same cycle
  task automatic t_done(input pin_drive_t [2:0] exp_jtag);
    done_in = 1'b1;
    for (int i = 0; i < 10 && cfg_done !== 1'b1; i++) cyc(1);
    done_in = 1'b0;
    `CHK(cfg_done, 1'b1)
    `CHK({hi_f, lo_f}, 4'hD)
    cyc(1);
    `CHK({rdy, hi_f, lo_f}, 6'h2A)
    `CHK(clr, 2'b00)
    `CHK(jtag, exp_jtag)
    cyc(5);
    `CHK({hi_f, lo_f, cfg_done}, 5'h15)
  endtask
  // other load modes leave ready and data bit undriven
  task automatic t_other;
    cyc(2);
    `CHK(hi_f, 2'b11)
    `CHK(lo_f, 2'b01)
    `CHK(clr, 2'b01)
    rd = 1'b1;
    cyc(8);
    `CHK(rdy.oe, 1'b0)
    `CHK(dbit.oe, 1'b0)
    rd = 1'b0;
    cyc(1);
  endtask
  task automatic conclude;
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {pwr, done_in, wr, rd} = 4'h0;
    {sel, hold} = 2'h3;
    fail_count = 0;
    n_tests = 0;
    do_reset(MODE_ASYNC_PERIPH, 1'b0);
    t_clear();
    t_wait();
    t_write();
    t_read();
    t_done({3{2'b11}});
    hold = 1'b0;
    do_reset(MODE_MASTER_PAR, 1'b1);
    cyc(80);
    t_strobe();
    t_done('0);
    do_reset(MODE_OTHER, 1'b0);
    t_other();
    conclude();
  end
  // run needs well under a thousand cycles
  initial begin
    #60000;
    fail_count++;
    conclude();
  end
endmodule
